// [nvc_pkg.sv]
// Purpose: shared constants and types for the nv sram pin controller
// Assumes: 200 MHz clock, pins sampled and driven synchronously
// Notes:   times kept in their own unit, cycle counts derived from them
package nvc_pkg;

  localparam int ADDR_W          = 13;
  localparam int DATA_W          = 8;
  localparam int CLK_MHZ         = 200;

  // least times in ns / us / ms
  localparam int STORE_INIT_NS   = 45;
  localparam int RECALL_INIT_NS  = 25;
  localparam int WR_PULSE_NS     = 35;
  localparam int RD_ACCESS_NS    = 45;
  localparam int RECALL_DUR_US   = 20;
  localparam int STORE_DUR_MS    = 10;

  // cycle counts, rounded up
  localparam int STORE_INIT_CYC  = (STORE_INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int RECALL_INIT_CYC = (RECALL_INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_PULSE_CYC    = (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_ACCESS_CYC   = (RD_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int RECALL_DUR_CYC  = RECALL_DUR_US * CLK_MHZ;
  localparam int STORE_DUR_CYC   = STORE_DUR_MS * 1000 * CLK_MHZ;

  localparam int TMR_W           = 21;

  typedef enum logic [1:0] {
    NVC_OP_READ,
    NVC_OP_WRITE,
    NVC_OP_STORE,
    NVC_OP_RECALL
  } nvc_op_e;

  typedef struct packed {
    nvc_op_e             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } nvc_cmd_s;

  typedef struct packed {
    logic                ce_n;
    logic                we_n;
    logic                oe_n;
    logic                nv_strobe_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_out;
    logic                dq_oe;
  } nvc_pins_s;

  localparam nvc_pins_s PINS_RST = '{
    ce_n:        1'h1,
    we_n:        1'h1,
    oe_n:        1'h1,
    nv_strobe_n: 1'h1,
    addr:        13'h0000,
    dq_out:      8'h00,
    dq_oe:       1'h0
  };

endpackage

// [nvc_timer.sv]
// Purpose: loadable down counter for pin phase timing
// Assumes: load wins over counting
// Notes:   expired is high while the count sits at zero
`timescale 1ns/1ps
module nvc_timer #(
  parameter int W = 21
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign expired = (cnt_ff == '0);

endmodule

// [nvc_host.sv]
// Purpose: host side controller driving an nv sram through its control pins
// Assumes: vcc_ok reports supply above 3.3V, synchronous to clk
// Notes:   one command at a time, no queue
`timescale 1ns/1ps
// Contract
// - hold ce, strobe and we low at least 45 ns before release
// - store initiation ended by releasing all control pins
// - hold the recall combination at least 25 ns
// - address held steady throughout a recall
module nvc_host #(
  parameter int STORE_CYC = nvc_pkg::STORE_DUR_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       vcc_ok,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire nvc_pkg::nvc_cmd_s          cmd,
  output logic [nvc_pkg::DATA_W-1:0]      rdata,
  output logic                            rvalid,
  output logic                            done,
  output logic                            powered,
  output nvc_pkg::nvc_pins_s              pins,
  input  wire logic [nvc_pkg::DATA_W-1:0] dq_in
);

  localparam int TW = nvc_pkg::TMR_W;

  typedef enum logic [3:0] {
    ST_PWR_OFF,
    ST_PWR_RCL,
    ST_IDLE,
    ST_RD,
    ST_RD_END,
    ST_WR,
    ST_WR_END,
    ST_ST_SET,
    ST_ST_INIT,
    ST_ST_BUSY,
    ST_RC_SET,
    ST_RC_INIT,
    ST_RC_BUSY
  } nvc_state_e;

  nvc_state_e                   state_ff;
  nvc_state_e                   nxt_state;
  nvc_pkg::nvc_pins_s           pins_ff;
  nvc_pkg::nvc_pins_s           nxt_pins;
  logic [nvc_pkg::DATA_W-1:0]   rdata_ff;
  logic [nvc_pkg::DATA_W-1:0]   nxt_rdata;
  logic                         rvalid_ff;
  logic                         nxt_rvalid;
  logic                         done_ff;
  logic                         nxt_done;
  logic                         tmr_load;
  logic [TW-1:0]                tmr_val;
  logic                         tmr_exp;
  logic                         accept;

  assign cmd_ready = (state_ff == ST_IDLE) && vcc_ok;
  assign accept    = cmd_valid && cmd_ready;
  assign pins      = pins_ff;
  assign rdata     = rdata_ff;
  assign rvalid    = rvalid_ff;
  assign done      = done_ff;
  assign powered   = (state_ff != ST_PWR_OFF) && (state_ff != ST_PWR_RCL);

  nvc_timer #(
    .W        (TW)
  ) u_timer (
    .clk      (clk),
    .nrst     (nrst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_exp)
  );

  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_PWR_OFF: begin
        if (vcc_ok) begin
          nxt_state = ST_PWR_RCL;
        end
      end
      ST_PWR_RCL: begin
        if (tmr_exp) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          unique case (cmd.op)
            nvc_pkg::NVC_OP_READ:   nxt_state = ST_RD;
            nvc_pkg::NVC_OP_WRITE:  nxt_state = ST_WR;
            nvc_pkg::NVC_OP_STORE:  nxt_state = ST_ST_SET;
            nvc_pkg::NVC_OP_RECALL: nxt_state = ST_RC_SET;
          endcase
        end
      end
      ST_RD:      nxt_state = tmr_exp ? ST_RD_END : ST_RD;
      ST_RD_END:  nxt_state = ST_IDLE;
      ST_WR:      nxt_state = tmr_exp ? ST_WR_END : ST_WR;
      ST_WR_END:  nxt_state = ST_IDLE;
      ST_ST_SET:  nxt_state = ST_ST_INIT;
      ST_ST_INIT: nxt_state = tmr_exp ? ST_ST_BUSY : ST_ST_INIT;
      ST_ST_BUSY: nxt_state = tmr_exp ? ST_IDLE : ST_ST_BUSY;
      ST_RC_SET:  nxt_state = ST_RC_INIT;
      ST_RC_INIT: nxt_state = tmr_exp ? ST_RC_BUSY : ST_RC_INIT;
      ST_RC_BUSY: nxt_state = tmr_exp ? ST_IDLE : ST_RC_BUSY;
    endcase
    if (!vcc_ok) begin
      nxt_state = ST_PWR_OFF;
    end
  end

  // timer load on entry to a timed phase
  always_comb begin
    tmr_load = (nxt_state != state_ff);
    tmr_val  = '0;
    unique case (nxt_state)
      ST_PWR_RCL: tmr_val = TW'(nvc_pkg::RECALL_DUR_CYC);
      ST_RD:      tmr_val = TW'(nvc_pkg::RD_ACCESS_CYC);
      ST_WR:      tmr_val = TW'(nvc_pkg::WR_PULSE_CYC);
      ST_ST_INIT: tmr_val = TW'(nvc_pkg::STORE_INIT_CYC);
      ST_ST_BUSY: tmr_val = TW'(STORE_CYC);
      ST_RC_INIT: tmr_val = TW'(nvc_pkg::RECALL_INIT_CYC);
      ST_RC_BUSY: tmr_val = TW'(nvc_pkg::RECALL_DUR_CYC);
      default:    tmr_val = '0;
    endcase
  end

  // pins and responses
  always_comb begin
    nxt_pins             = pins_ff;
    nxt_pins.ce_n        = 1'h1;
    nxt_pins.we_n        = 1'h1;
    nxt_pins.oe_n        = 1'h1;
    nxt_pins.nv_strobe_n = 1'h1;
    nxt_pins.dq_oe       = 1'h0;
    nxt_rdata            = rdata_ff;
    nxt_rvalid           = 1'h0;
    nxt_done             = 1'h0;
    if (accept) begin
      nxt_pins.addr   = cmd.addr;
      nxt_pins.dq_out = cmd.wdata;
    end
    unique case (nxt_state)
      ST_RD: begin
        nxt_pins.ce_n = 1'h0;
        nxt_pins.oe_n = 1'h0;
      end
      ST_WR: begin
        nxt_pins.ce_n  = 1'h0;
        nxt_pins.we_n  = 1'h0;
        nxt_pins.dq_oe = 1'h1;
      end
      ST_WR_END: begin
        nxt_pins.dq_oe = 1'h1;
      end
      ST_ST_SET: begin
        nxt_pins.ce_n        = 1'h0;
        nxt_pins.nv_strobe_n = 1'h0;
      end
      ST_ST_INIT: begin
        nxt_pins.ce_n        = 1'h0;
        nxt_pins.we_n        = 1'h0;
        nxt_pins.nv_strobe_n = 1'h0;
      end
      ST_RC_SET: begin
        nxt_pins.oe_n        = 1'h0;
        nxt_pins.nv_strobe_n = 1'h0;
      end
      ST_RC_INIT: begin
        nxt_pins.ce_n        = 1'h0;
        nxt_pins.oe_n        = 1'h0;
        nxt_pins.nv_strobe_n = 1'h0;
      end
      // busy phases release every control pin
      ST_ST_BUSY: nxt_pins.nv_strobe_n = 1'h1;
      ST_RC_BUSY: nxt_pins.nv_strobe_n = 1'h1;
      default: begin
      end
    endcase
    if ((state_ff == ST_RD) && (nxt_state == ST_RD_END)) begin
      nxt_rdata  = dq_in;
      nxt_rvalid = 1'h1;
    end
    if ((nxt_state == ST_IDLE) && (state_ff != ST_IDLE) && (state_ff != ST_PWR_RCL)) begin
      nxt_done = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff  <= ST_PWR_OFF;
      pins_ff   <= nvc_pkg::PINS_RST;
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'h0;
      done_ff   <= 1'h0;
    end else begin
      state_ff  <= nxt_state;
      pins_ff   <= nxt_pins;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      done_ff   <= nxt_done;
    end
  end

endmodule

// [nvc_sva.sv]
// Purpose: pin and command timing checks for nvc_host
// Assumes: bound into nvc_host, single clock domain
// Notes:   long recall wait is timed in the bench
`timescale 1ns/1ps
module nvc_sva #(
  parameter int STORE_CYC = 20
) (
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire logic                       vcc_ok,
  input wire logic                       cmd_valid,
  input wire logic                       cmd_ready,
  input wire nvc_pkg::nvc_cmd_s          cmd,
  input wire logic [nvc_pkg::DATA_W-1:0] rdata,
  input wire logic                       rvalid,
  input wire logic                       done,
  input wire logic                       powered,
  input wire nvc_pkg::nvc_pins_s         pins,
  input wire logic [nvc_pkg::DATA_W-1:0] dq_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  localparam int ST_LO = STORE_CYC + 12;
  localparam int ST_HI = STORE_CYC + 14;
  logic tk;
  assign tk = cmd_valid && cmd_ready;
  chk_no_all_low: assert property (
    pins.ce_n | pins.we_n | pins.oe_n | pins.nv_strobe_n) else $error("all control pins low");
  chk_dq_quiet_nv: assert property (pins.dq_oe |-> pins.nv_strobe_n)
    else $error("data bus driven in nv cycle");
  chk_store_hold: assert property (
    $fell(pins.we_n) && !pins.ce_n && !pins.nv_strobe_n |->
    (!pins.we_n && !pins.ce_n && !pins.nv_strobe_n) [*8] ##1 (!pins.we_n && !pins.ce_n))
    else $error("store initiation too short");
  chk_recall_hold: assert property (
    $fell(pins.ce_n) && pins.we_n && !pins.oe_n && !pins.nv_strobe_n |->
    (!pins.ce_n && !pins.nv_strobe_n) [*5]) else $error("recall initiation too short");
  chk_read_pins: assert property (tk && cmd.op == nvc_pkg::NVC_OP_READ |=>
    !pins.ce_n && !pins.oe_n && pins.we_n && pins.nv_strobe_n ##10 rvalid)
    else $error("read cycle wrong");
  chk_write_pins: assert property (tk && cmd.op == nvc_pkg::NVC_OP_WRITE |=>
    !pins.ce_n && !pins.we_n && pins.nv_strobe_n && pins.dq_oe && pins.dq_out == $past(cmd.wdata))
    else $error("write cycle wrong");
  chk_store_pins: assert property (tk && cmd.op == nvc_pkg::NVC_OP_STORE |=>
    ##1 !pins.ce_n && !pins.we_n && pins.oe_n && !pins.nv_strobe_n) else $error("store pins");
  chk_recall_pins: assert property (tk && cmd.op == nvc_pkg::NVC_OP_RECALL |=>
    ##1 !pins.ce_n && pins.we_n && !pins.oe_n && !pins.nv_strobe_n) else $error("recall pins");
  chk_store_wait: assert property (@(posedge clk) disable iff (!nrst || !vcc_ok)
    tk && cmd.op == nvc_pkg::NVC_OP_STORE |-> ##[ST_LO:ST_HI] done) else $error("store time");
  chk_ready_supply: assert property (!vcc_ok |-> !cmd_ready ##1 !powered)
    else $error("ready while supply low");
  chk_addr_steady: assert property ($changed(pins.addr) |-> $past(tk))
    else $error("address moved outside command take");
  cov_read: cover property (rvalid);
  cov_store: cover property (tk && cmd.op == nvc_pkg::NVC_OP_STORE);
  cov_recall: cover property (tk && cmd.op == nvc_pkg::NVC_OP_RECALL);
endmodule

// [nvc_dev.sv]
// Purpose: behavioural nv sram seen at the host pins
// Assumes: pins sampled on clk for writes and nv transfers, read data driven straight from the pins; transfers done at initiation
// Notes:   undriven data bus shows a toggling pattern
`timescale 1ns/1ps
module nvc_dev (
  input  wire logic               clk,
  input  wire logic               vcc_ok,
  input  wire nvc_pkg::nvc_pins_s pins,
  output logic [7:0]              dq
);
  logic [7:0] sram [8192];
  logic [7:0] ee   [8192];
  logic [7:0] last;
  logic       vcc_q;
  logic       rd;
  initial begin
    for (int i = 0; i < 8192; i++) ee[i] = i[7:0] ^ 8'hA5;
    vcc_q = 1'b0;
    last  = 8'h00;
  end
  assign rd = !pins.ce_n && !pins.oe_n && pins.we_n && pins.nv_strobe_n;
  assign dq = rd ? sram[pins.addr] : ~last;
  always @(posedge clk) begin
    last  <= dq;
    vcc_q <= vcc_ok;
    if (vcc_ok && !vcc_q) sram <= ee;
    if (!pins.ce_n && !pins.we_n && pins.nv_strobe_n) sram[pins.addr] <= pins.dq_out;
    if (!pins.ce_n && !pins.we_n && pins.oe_n && !pins.nv_strobe_n && vcc_ok) begin
      ee <= sram;
    end
    if (!pins.ce_n && pins.we_n && !pins.oe_n && !pins.nv_strobe_n) begin
      sram <= ee;
    end
  end
endmodule

// [tb.sv]
// Purpose: self-checking bench for nvc_host with a device model
// Assumes: store time shortened through STORE_CYC
// Notes:   inputs change 1 ns after each rising edge
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module tb;
  localparam int STORE_CYC = 20;
  logic clk = 1'b0, nrst = 1'b0, vcc_ok = 1'b1, cmd_valid = 1'b0;
  logic cmd_ready, rvalid, done, powered;
  logic [7:0] rdata, dq_in, got;
  nvc_pkg::nvc_cmd_s  cmd = '0;
  nvc_pkg::nvc_pins_s pins;
  int miscompares = 0, n_checks = 0, cyc = 0, busy;
  bit hung = 1'b0;
  always #2.5 clk = ~clk;
  nvc_host #(.STORE_CYC(STORE_CYC)) nvc_host_i (.clk(clk), .nrst(nrst), .vcc_ok(vcc_ok),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rdata(rdata), .rvalid(rvalid),
    .done(done), .powered(powered), .pins(pins), .dq_in(dq_in));
  nvc_dev nvc_dev_i (.clk(clk), .vcc_ok(vcc_ok), .pins(pins), .dq(dq_in));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000 || hung) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic send(input nvc_pkg::nvc_op_e op, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 9000) begin
      @(posedge clk); #1; n++;
    end
    if (cmd_ready !== 1'b1) hung = 1'b1;
    cmd = '{op: op, addr: a, wdata: d};
    cmd_valid = 1'b1;
    @(posedge clk); #1;
    cmd_valid = 1'b0;
    busy = 0;
    while (done !== 1'b1 && busy < 9000) begin
      @(posedge clk); #1; busy++;
    end
    if (done !== 1'b1) hung = 1'b1;
    got = rdata;
  endtask
  task automatic t_powerup();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 9000) begin
      @(posedge clk); #1; n++;
    end
    if (cmd_ready !== 1'b1) hung = 1'b1;
    `CHK(n >= nvc_pkg::RECALL_DUR_CYC, 1'b1)
    send(nvc_pkg::NVC_OP_READ, 13'h0005, 8'h00);
    `CHK(got, 8'h05 ^ 8'hA5)
    $display("test powerup done");
  endtask
  task automatic t_wr_rd();
    send(nvc_pkg::NVC_OP_WRITE, 13'h1FFF, 8'h3C);
    send(nvc_pkg::NVC_OP_READ, 13'h1FFF, 8'h00);
    `CHK(got, 8'h3C)
    $display("test write read done");
  endtask
  task automatic t_nv();
    send(nvc_pkg::NVC_OP_WRITE, 13'h0007, 8'h77);
    send(nvc_pkg::NVC_OP_STORE, 13'h0007, 8'h00);
    `CHK(busy >= STORE_CYC, 1'b1)
    send(nvc_pkg::NVC_OP_WRITE, 13'h0007, 8'h11);
    send(nvc_pkg::NVC_OP_RECALL, 13'h0007, 8'h00);
    `CHK(busy >= nvc_pkg::RECALL_DUR_CYC, 1'b1)
    send(nvc_pkg::NVC_OP_READ, 13'h0007, 8'h00);
    `CHK(got, 8'h77)
    $display("test store recall done");
  endtask
  task automatic t_supply();
    send(nvc_pkg::NVC_OP_WRITE, 13'h0007, 8'h99);
    vcc_ok = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK({cmd_ready, powered}, 2'b00)
    vcc_ok = 1'b1;
    send(nvc_pkg::NVC_OP_READ, 13'h0007, 8'h00);
    `CHK(got, 8'h77)
    $display("test supply done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_powerup();
    t_wr_rd();
    t_nv();
    t_supply();
    end_sim();
  end
endmodule
bind nvc_host nvc_sva #(.STORE_CYC(STORE_CYC)) nvc_sva_i (.clk(clk), .nrst(nrst),
  .vcc_ok(vcc_ok), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rdata(rdata),
  .rvalid(rvalid), .done(done), .powered(powered), .pins(pins), .dq_in(dq_in));
